// ---- sim/flash_model.sv ----
// Behavioural parallel flash that answers the host controller's pins.
// Assumes the pins come straight from flash_host; it has no clock of its own.
`timescale 1ns/1ps
module flash_model
    import flash_host_pkg::*;
#(
    parameter logic [7:0] ID_CODE = 8'h3c, // Arbitrary value.
    parameter logic [7:0] QRY_CODE = 8'h6e, // Arbitrary value.
    parameter int BUSY_NS = 4000,
    parameter bit PROG_OK = 1'b1
) (
    input wire logic [23:0] flash_addr,
    input wire flash_ctl_t flash_ctl,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    output logic [15:0] dq_in,
    output logic busy_status_out
);
    logic enabled, reading, running = 1'b0, id_mode = 1'b0, qry_mode = 1'b0, prog_next = 1'b0;
    logic [15:0] val, last = 16'h0;
    assign enabled = flash_ctl.reset_powerdown_n && (flash_ctl.chip_select_bit2
        ? !(flash_ctl.chip_select_bit1 && flash_ctl.chip_select_bit0)
        : !(flash_ctl.chip_select_bit1 || flash_ctl.chip_select_bit0));
    assign reading = enabled && !flash_ctl.oe_n && flash_ctl.we_n;
    assign busy_status_out = !running;
    always_comb begin
        if (running) val = {~last[15:8], 1'b0, ~last[6:0]};
        else if (id_mode) val = {8'h00, ID_CODE ^ {6'h0, flash_addr[2:1]}};
        else if (qry_mode) val = {8'h00, QRY_CODE ^ flash_addr[7:0]};
        else val = flash_addr[15:0] ^ 16'ha5c3;
        if (!flash_ctl.byte_n) val[15:8] = ~last[15:8];
    end
    // Released bits show the inverse of the last bus value so a stale read cannot pass.
    assign dq_in = dq_oe ? dq_out : (reading ? val : ~last);
    always @(posedge flash_ctl.oe_n or posedge flash_ctl.we_n) last = dq_in;
    task automatic take(input logic [15:0] d);
        if (prog_next) begin
            prog_next = 1'b0;
            running = PROG_OK;
        end else if (d[7:0] == 8'h90) begin
            id_mode = 1'b1;
            qry_mode = 1'b0;
        end else if (d[7:0] == 8'h98) begin
            qry_mode = 1'b1;
            id_mode = 1'b0;
        end else if (d[7:0] == 8'hff) begin
            id_mode = 1'b0;
            qry_mode = 1'b0;
        end else if (d[7:0] == 8'h40) prog_next = 1'b1;
    endtask : take
    always @(posedge flash_ctl.we_n) if (enabled && flash_ctl.oe_n) take(dq_in);
    always @(negedge enabled) if (!flash_ctl.we_n && flash_ctl.oe_n) take(dq_in);
    // Deselection does not stop the sequencer; only the power-down pin does.
    always begin
        wait (running);
        #(BUSY_NS);
        running = 1'b0;
    end
    always @(negedge flash_ctl.reset_powerdown_n) begin
        running = 1'b0;
        id_mode = 1'b0;
        qry_mode = 1'b0;
        prog_next = 1'b0;
    end
endmodule : flash_model

// ---- sim/tb_top.sv ----
// Self-checking bench for flash_host against the behavioural flash.
// Assumes the design's own reset and wake-up timing from its constants header.
`timescale 1ns/1ps
`include "flash_host_consts.svh"
module tb_top;
    import flash_host_pkg::*;
    localparam logic [7:0] ID = 8'h3c;
    localparam logic [7:0] QRY = 8'h6e;
    logic mclk = 1'b0, rst = 1'b1, req_valid = 1'b0, wide_mode = 1'b1, powerdown_req = 1'b0;
    host_req_t req = '0;
    logic req_ready, rdata_valid, flash_busy, dq_oe, busy_status_out;
    logic [15:0] rdata, dq_in, dq_out, e;
    logic [23:0] flash_addr, a;
    flash_ctl_t flash_ctl;
    logic [15:0] expq[$];
    int mismatches = 0, total_checks = 0, seed = 88, n;
    flash_host dut_u (.mclk(mclk), .rst(rst), .req(req), .req_valid(req_valid), .wide_mode(wide_mode),
        .powerdown_req(powerdown_req), .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid),
        .flash_busy(flash_busy), .flash_addr(flash_addr), .flash_ctl(flash_ctl), .dq_in(dq_in),
        .dq_out(dq_out), .dq_oe(dq_oe), .busy_status_out(busy_status_out));
    flash_model #(.ID_CODE(ID), .QRY_CODE(QRY)) model_u (.flash_addr(flash_addr), .flash_ctl(flash_ctl),
        .dq_out(dq_out),
        .dq_oe(dq_oe), .dq_in(dq_in), .busy_status_out(busy_status_out));
    initial forever #10 mclk = ~mclk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic end_of_test();
        $display("Counts: %0d checks, %0d mismatches", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : end_of_test
    // A wait that runs out is a failure, so a hung design still reaches the report.
    task automatic wait_for(input int sel, input int lim);
        int k;
        k = 0;
        while (k < lim && !(sel == 0 ? req_ready === 1'b1 : sel == 1 ? flash_busy === 1'b1
            : flash_ctl.reset_powerdown_n === 1'b0)) begin
            @(posedge mclk);
            #1;
            k++;
        end
        if (k >= lim) begin
            mismatches++;
            end_of_test();
        end
    endtask : wait_for
    task automatic issue(input logic w, input logic [23:0] ad, input logic [15:0] d);
        wait_for(0, 100);
        req = '{write: w, addr: ad, wdata: d};
        req_valid = 1'b1;
        @(posedge mclk);
        #1;
        req_valid = 1'b0;
        @(posedge mclk);
        #1;
    endtask : issue
    task automatic rd(input logic [23:0] ad, input logic [15:0] exp);
        expq.push_back(exp);
        issue(1'b0, ad, 16'h0);
    endtask : rd
    // Sampled mid-cycle so the one-cycle pulse is seen once and away from the edge that launches it.
    always @(negedge mclk) if (rdata_valid === 1'b1) begin
        if (expq.size() > 0) check(rdata, expq.pop_front());
        else check(rdata, 16'hxxxx);
    end
    initial begin
        repeat (6) @(posedge mclk);
        #1;
        check(flash_ctl.reset_powerdown_n, 16'h0);
        rst = 1'b0;
        n = 0;
        while (flash_ctl.reset_powerdown_n !== 1'b1 && n < 2000) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check(16'(n >= `RESET_PULSE_CYC && n < 2000), 16'h1);
        wait_for(0, 100);
        repeat (`WAKE_WRITE_CYC + 2) @(posedge mclk);
        #1;
        $display("test reset done");
        for (int i = 0; i < 8; i++) begin
            wait_for(0, 100);
            wide_mode = i[0];
            a = 24'($random(seed));
            e = a[15:0] ^ 16'ha5c3;
            rd(a, i[0] ? e : e & 16'h00ff);
        end
        wait_for(0, 100);
        wide_mode = 1'b1;
        $display("test reads done");
        issue(1'b1, 24'h0, 16'h0090);
        for (int i = 0; i < 8; i++) rd(24'(i), {8'h00, ID ^ 8'(i / 2)});
        $display("test ident done");
        issue(1'b1, 24'h0, 16'h0098);
        for (int i = 0; i < 4; i++) rd(24'(i * 3), {8'h00, QRY ^ 8'(i * 3)});
        issue(1'b1, 24'h0, 16'h00ff);
        rd(24'h000010, 16'h0010 ^ 16'ha5c3);
        wait_for(0, 100);
        check(flash_busy, 16'h0);
        $display("test query done");
        issue(1'b1, 24'h000100, 16'h0040);
        issue(1'b1, 24'h000100, 16'h1234);
        // Busy trails the strobe by the synchroniser, so it is looked at a fixed few cycles later.
        repeat (8) @(posedge mclk);
        #1;
        check(flash_busy, 16'h1);
        powerdown_req = 1'b1;
        wait_for(2, 50);
        @(posedge mclk);
        #1;
        powerdown_req = 1'b0;
        wait_for(0, 2000);
        repeat (`WAKE_WRITE_CYC + 2) @(posedge mclk);
        #1;
        check(flash_busy, 16'h0);
        rd(24'h000004, 16'h000004 ^ 16'ha5c3);
        wait_for(0, 100);
        repeat (4) @(posedge mclk);
        #1;
        $display("test abort done");
        check(16'(expq.size()), 16'h0);
        end_of_test();
    end
endmodule : tb_top

// ---- verilog/flash_host.sv ----
// Host-side controller that drives an asynchronous parallel NOR flash.
// Assumes one request source on mclk and the flash pins wired straight out.
`timescale 1ns/1ps
`include "flash_host_consts.svh"
// How it works
// - Hold powerdown low the minimum time, then wait wake-up before reading.
// - Wait the wake-to-write delay after raising powerdown before any write.
// - Powerdown pin follows the system reset.
// - Never assert output enable and write strobe together.
// - Host supplies block, location or device address as the command needs.
module flash_host
    import flash_host_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire host_req_t req,
    input wire logic req_valid,
    input wire logic wide_mode,
    input wire logic powerdown_req,
    output logic req_ready,
    output logic [15:0] rdata,
    output logic rdata_valid,
    output logic flash_busy,
    output logic [23:0] flash_addr,
    output flash_ctl_t flash_ctl,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe,
    input wire logic busy_status_out
);
    typedef enum {S_PD, S_WAKE, S_IDLE, S_RD, S_WR, S_HOLD} state_t;
    state_t state, next_state;
    logic [`CNT_W-1:0] cnt, next_cnt;
    logic [`CNT_W-1:0] wake_cnt, next_wake_cnt;
    logic is_write, next_is_write;
    logic req_ready_n, rdv_n, busy_n, oe_n_d;
    logic [15:0] rdata_n, dq_out_n;
    logic [23:0] addr_n;
    flash_ctl_t ctl_n;
    logic busy_sync;
    logic [15:0] dq_sync;

    // Status pin is open drain; it reads high when the sequencer is idle.
    pin_sync #(.W(1)) u_busy_sync (
        .mclk(mclk),
        .rst(rst),
        .din(busy_status_out),
        .dout(busy_sync)
    );

    // Read data comes from another timing domain, so it is resynchronised like the status pin.
    pin_sync #(.W(16)) u_dq_sync (
        .mclk(mclk),
        .rst(rst),
        .din(dq_in),
        .dout(dq_sync)
    );

    // The top select stays low, so the two lower selects alone choose between enabled and standby.
    function automatic flash_ctl_t idle_ctl(input logic pd_n, input logic wide, input logic sel);
        flash_ctl_t c;
        c.chip_select_bit2 = 1'b0;
        c.chip_select_bit1 = !sel;
        c.chip_select_bit0 = !sel;
        c.oe_n = 1'b1;
        c.we_n = 1'b1;
        c.reset_powerdown_n = pd_n;
        c.byte_n = wide;
        return c;
    endfunction : idle_ctl

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_wake_cnt = wake_cnt;
        next_is_write = is_write;
        req_ready_n = 1'b0;
        rdv_n = 1'b0;
        rdata_n = rdata;
        addr_n = flash_addr;
        dq_out_n = dq_out;
        oe_n_d = 1'b0;
        ctl_n = idle_ctl(1'b1, wide_mode, 1'b0);
        busy_n = !busy_sync;
        if (wake_cnt != '0) begin
            next_wake_cnt = wake_cnt - `CNT_W'(1);
        end
        case (state)
            S_PD: begin
                ctl_n = idle_ctl(1'b0, wide_mode, 1'b0);
                busy_n = 1'b1;
                if (cnt != '0) begin
                    next_cnt = cnt - `CNT_W'(1);
                end else if (!powerdown_req) begin
                    next_state = S_WAKE;
                    next_cnt = `CNT_W'(`WAKE_READ_CYC);
                    next_wake_cnt = `CNT_W'(`WAKE_WRITE_CYC);
                end
            end
            S_WAKE: begin
                if (cnt != '0) begin
                    next_cnt = cnt - `CNT_W'(1);
                end else begin
                    next_state = S_IDLE;
                    req_ready_n = 1'b1;
                end
            end
            S_IDLE: begin
                req_ready_n = 1'b1;
                if (powerdown_req) begin
                    // Aborting a running operation leaves its target undefined.
                    next_state = S_PD;
                    next_cnt = `CNT_W'(`RESET_PULSE_CYC);
                    req_ready_n = 1'b0;
                end else if (req_valid && !(req.write && wake_cnt != '0)) begin
                    req_ready_n = 1'b0;
                    next_is_write = req.write;
                    addr_n = req.addr;
                    dq_out_n = wide_mode ? req.wdata : (req.wdata & `LOW_BYTE_MASK);
                    next_state = req.write ? S_WR : S_RD;
                    // Reads stay open two extra cycles to cover the data synchroniser's latency.
                    next_cnt = req.write ? `CNT_W'(`STROBE_CYC) : `CNT_W'(`ACCESS_CYC + `SYNC_CYC);
                end
            end
            S_RD: begin
                ctl_n = idle_ctl(1'b1, wide_mode, 1'b1);
                ctl_n.oe_n = 1'b0;
                if (cnt != '0) begin
                    next_cnt = cnt - `CNT_W'(1);
                end else begin
                    // Narrow mode: upper lanes are not driven by the flash.
                    rdata_n = wide_mode ? dq_sync : (dq_sync & `LOW_BYTE_MASK);
                    rdv_n = 1'b1;
                    ctl_n.oe_n = 1'b1;
                    next_state = S_HOLD;
                    next_cnt = `CNT_W'(`HOLD_CYC);
                end
            end
            S_WR: begin
                ctl_n = idle_ctl(1'b1, wide_mode, 1'b1);
                ctl_n.we_n = 1'b0;
                oe_n_d = 1'b1;
                if (cnt != '0) begin
                    next_cnt = cnt - `CNT_W'(1);
                end else begin
                    // Rising write strobe latches the command; data held one more phase.
                    ctl_n.we_n = 1'b1;
                    next_state = S_HOLD;
                    next_cnt = `CNT_W'(`HOLD_CYC);
                end
            end
            S_HOLD: begin
                // Selects stay on through the hold so the write strobe, not a select edge, latches.
                ctl_n = idle_ctl(1'b1, wide_mode, 1'b1);
                oe_n_d = is_write;
                if (cnt != '0) begin
                    next_cnt = cnt - `CNT_W'(1);
                end else begin
                    next_state = S_IDLE;
                    req_ready_n = !powerdown_req;
                end
            end
            default: begin
                next_state = S_PD;
                next_cnt = `CNT_W'(`RESET_PULSE_CYC);
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            // System reset also drives the flash into power-down.
            state <= S_PD;
            cnt <= `CNT_W'(`RESET_PULSE_CYC);
            wake_cnt <= '0;
            is_write <= 1'b0;
            req_ready <= 1'b0;
            rdata <= '0;
            rdata_valid <= 1'b0;
            flash_busy <= 1'b1;
            flash_addr <= '0;
            flash_ctl <= idle_ctl(1'b0, 1'b0, 1'b0);
            dq_out <= '0;
            dq_oe <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            wake_cnt <= next_wake_cnt;
            is_write <= next_is_write;
            req_ready <= req_ready_n;
            rdata <= rdata_n;
            rdata_valid <= rdv_n;
            flash_busy <= busy_n;
            flash_addr <= addr_n;
            flash_ctl <= ctl_n;
            dq_out <= dq_out_n;
            dq_oe <= oe_n_d;
        end
    end

    no_oe_we_a: assert property (@(posedge mclk) disable iff (rst)
        !(!flash_ctl.oe_n && !flash_ctl.we_n)) else $error("oe and we both active");
    no_drive_read_a: assert property (@(posedge mclk) disable iff (rst)
        !flash_ctl.oe_n |-> !dq_oe) else $error("host drives dq during read");
    pd_width_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(flash_ctl.reset_powerdown_n) |-> !flash_ctl.reset_powerdown_n [*8])
        else $error("powerdown pulse too short");
    wake_write_a: assert property (@(posedge mclk) disable iff (rst)
        $rose(flash_ctl.reset_powerdown_n) |-> flash_ctl.we_n [*8]) else $error("write too soon");
    pd_quiet_a: assert property (@(posedge mclk) disable iff (rst)
        !flash_ctl.reset_powerdown_n |-> flash_ctl.oe_n && flash_ctl.we_n) else $error("access in powerdown");
    we_drive_a: assert property (@(posedge mclk) disable iff (rst)
        !flash_ctl.we_n |-> dq_oe) else $error("write without data");
    rd_len_a: assert property (@(posedge mclk) disable iff (rst)
        $fell(flash_ctl.oe_n) |-> !flash_ctl.oe_n [*8]) else $error("read strobe short");
    rdv_pulse_a: assert property (@(posedge mclk) disable iff (rst)
        rdata_valid |=> !rdata_valid) else $error("rdata_valid not a pulse");
    cov_read_c: cover property (@(posedge mclk) rdata_valid);
    cov_write_c: cover property (@(posedge mclk) $rose(flash_ctl.we_n));
    cov_pd_c: cover property (@(posedge mclk) $rose(flash_ctl.reset_powerdown_n));
endmodule : flash_host

// ---- verilog/flash_host_consts.svh ----
// Timing and field constants for the parallel flash host controller.
// Assumes a 50 MHz mclk; all counts except SYNC_CYC are derived from printed times in ns.
`ifndef FLASH_HOST_CONSTS_SVH
`define FLASH_HOST_CONSTS_SVH
`define CLK_PERIOD_NS 20
`define RESET_PULSE_MIN_NS 25000
`define WAKE_TO_DATA_VALID_NS 150
`define WAKE_TO_WRITE_DELAY_NS 1000
`define RESET_RECOVERY_TIME_NS 100
`define ACCESS_NS 150
`define STROBE_NS 70
`define HOLD_NS 20
`define CEIL_CYC(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RESET_PULSE_CYC `CEIL_CYC(`RESET_PULSE_MIN_NS)
`define WAKE_READ_CYC `CEIL_CYC(`WAKE_TO_DATA_VALID_NS)
`define WAKE_WRITE_CYC `CEIL_CYC(`WAKE_TO_WRITE_DELAY_NS)
`define ACCESS_CYC `CEIL_CYC(`ACCESS_NS)
`define STROBE_CYC `CEIL_CYC(`STROBE_NS)
`define HOLD_CYC `CEIL_CYC(`HOLD_NS)
`define SYNC_CYC 2
`define CNT_W 16
`define READ_ARRAY_CMD 8'hff
`define LOW_BYTE_MASK 16'h00ff
`endif

// ---- verilog/flash_host_pkg.sv ----
// Types shared by the parallel flash host controller.
// Assumes the constants header is compiled alongside.
package flash_host_pkg;
    typedef struct packed {
        logic write;
        logic [23:0] addr;
        logic [15:0] wdata;
    } host_req_t;
    typedef struct packed {
        logic chip_select_bit0;
        logic chip_select_bit1;
        logic chip_select_bit2;
        logic oe_n;
        logic we_n;
        logic reset_powerdown_n;
        logic byte_n;
    } flash_ctl_t;
endpackage : flash_host_pkg

// ---- verilog/pin_sync.sv ----
// Two-flop synchroniser for the flash status pin and the read data bus.
// Assumes inputs are asynchronous to mclk.
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_dout;
    always_comb begin
        next_meta = din;
        next_dout = meta;
    end
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta <= '0;
            dout <= '0;
        end else begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule : pin_sync
